// File: opfr_regs.svh
`ifndef OPFR_REGS_SVH
`define OPFR_REGS_SVH
// Register indices on the control interface.
`define OPFR_CTRL2_ADDR      8'h02
`define OPFR_CTRL3_ADDR      8'h03
`define OPFR_CTRL2_RESET     16'h0000
`define OPFR_CTRL3_RESET     16'h0000
// Field positions of the first register.
`define OPFR_C2_ARST_HI      15
`define OPFR_C2_ARST_LO      10
`define OPFR_C2_EC_ARST      9
`define OPFR_C2_IPWM_EN      8
`define OPFR_C2_HB_PWM_HI    7
`define OPFR_C2_HB_PWM_LO    2
`define OPFR_C2_EC_PWM       1
`define OPFR_C2_FULL_SCALE   0
// Field positions of the second register.
`define OPFR_C3_ARST_HI      15
`define OPFR_C3_ARST_LO      11
`define OPFR_C3_HS_PWM_HI    10
`define OPFR_C3_HS_PWM_LO    6
`define OPFR_C3_RATE         5
`define OPFR_C3_SUPPLY       4
`define OPFR_C3_SENSE_HI     3
`define OPFR_C3_SENSE_LO     0
// Restart delays in microseconds and their cycle counts at 100 MHz.
`define OPFR_CLK_MHZ         100
`define OPFR_SLOW_US         1000
`define OPFR_FAST_US         100
`define OPFR_BULB_US         500
`define OPFR_SLOW_CYC        (`OPFR_SLOW_US * `OPFR_CLK_MHZ)
`define OPFR_FAST_CYC        (`OPFR_FAST_US * `OPFR_CLK_MHZ)
`define OPFR_BULB_CYC        (`OPFR_BULB_US * `OPFR_CLK_MHZ)
// Full-scale clamp code: 1.2 V of 1.5 V over 64 steps.
`define OPFR_DAC_CLAMP       6'h33
`endif

// File: opfr_pkg.sv
package opfr_pkg;
  typedef enum logic [1:0] {
    OPFR_RUN = 2'b01,
    OPFR_OFF = 2'b10
  } opfr_out_state_t;
endpackage

// File: opfr_ctrl.sv
`timescale 1ns/1ps
`include "opfr_regs.svh"
module opfr_ctrl
  import opfr_pkg::*;
#(
  parameter int N_OUT    = 11,
  parameter int SLOW_CYC = `OPFR_SLOW_CYC,
  parameter int FAST_CYC = `OPFR_FAST_CYC,
  parameter int BULB_CYC = `OPFR_BULB_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  output logic      [15:0]       reg_rdata,
  // Output requests and faults, index 0 is output one, 11 is the EC pull-down
  input  wire logic [11:0]       out_en,
  input  wire logic [11:0]       overcurrent,
  input  wire logic [1:0]        bulb_mode,
  input  wire logic              internal_pwm_in,
  input  wire logic              pwm_in_a,
  input  wire logic              pwm_in_b,
  input  wire logic [5:0]        dac_code,
  // Supply faults and their clear
  input  wire logic              supply_over_evt,
  input  wire logic              supply_under_evt,
  input  wire logic              supply_good,
  input  wire logic              supply_flag_clr,
  // Drives and status
  output logic      [11:0]       power_output,
  output logic      [11:0]       per_output_overcurrent_flag,
  output logic                   global_fault_flag,
  output logic                   supply_over_flag,
  output logic                   supply_under_flag,
  output logic                   supply_shutdown,
  output logic                   internal_pwm_run,
  output logic      [5:0]        dac_out_code,
  output logic      [3:0]        sense_out_idx,
  output logic                   sense_active
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [15:0] ctrl2_q;
  logic [15:0] ctrl3_q;
  wire         wr2 = reg_wr && (reg_addr == `OPFR_CTRL2_ADDR);
  wire         wr3 = reg_wr && (reg_addr == `OPFR_CTRL3_ADDR);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl2_q <= `OPFR_CTRL2_RESET;
      ctrl3_q <= `OPFR_CTRL3_RESET;
    end else begin
      if (wr2) ctrl2_q <= reg_wdata;
      if (wr3) ctrl3_q <= reg_wdata;
    end
  end

  // Unmapped addresses read as zero.
  assign reg_rdata = (reg_addr == `OPFR_CTRL2_ADDR) ? ctrl2_q :
                     (reg_addr == `OPFR_CTRL3_ADDR) ? ctrl3_q : 16'h0000;

  // ******************************************************************
  // Field decode
  // ******************************************************************
  wire [5:0]  arst_hb  = ctrl2_q[`OPFR_C2_ARST_HI:`OPFR_C2_ARST_LO];
  wire [4:0]  arst_hs  = ctrl3_q[`OPFR_C3_ARST_HI:`OPFR_C3_ARST_LO];
  wire [5:0]  gate_hb  = ctrl2_q[`OPFR_C2_HB_PWM_HI:`OPFR_C2_HB_PWM_LO];
  wire [4:0]  gate_hs  = ctrl3_q[`OPFR_C3_HS_PWM_HI:`OPFR_C3_HS_PWM_LO];
  wire        ipwm_en  = ctrl2_q[`OPFR_C2_IPWM_EN];
  wire        rate_sel = ctrl3_q[`OPFR_C3_RATE];
  wire        sup_off  = ctrl3_q[`OPFR_C3_SUPPLY];
  wire        full_scl = ctrl2_q[`OPFR_C2_FULL_SCALE];
  wire [3:0]  sense    = ctrl3_q[`OPFR_C3_SENSE_HI:`OPFR_C3_SENSE_LO];

  // Both registers list their outputs with the lowest number in the top bit,
  // so each field is mirrored here to give bit i to output i+1 in the half-bridge fields and to output i+7 in the high-side fields.
  wire [5:0]  arst_hb_m;
  wire [4:0]  arst_hs_m;
  wire [5:0]  gate_hb_m;
  wire [4:0]  gate_hs_m;
  genvar r;
  generate
    for (r = 0; r < 6; r++) begin : g_mirror
      assign arst_hb_m[r] = arst_hb[5-r];
      assign gate_hb_m[r] = gate_hb[5-r];
      if (r < 5) begin : g_hs
        assign arst_hs_m[r] = arst_hs[4-r];
        assign gate_hs_m[r] = gate_hs[4-r];
      end
    end
  endgenerate
  // Index 11 is the EC pull-down, whose bits sit apart from the output fields.
  wire [11:0] arst_en  = {ctrl2_q[`OPFR_C2_EC_ARST], arst_hs_m, arst_hb_m};
  wire [11:0] gate_sel = {ctrl2_q[`OPFR_C2_EC_PWM], gate_hs_m, gate_hb_m};

  // ******************************************************************
  // PWM source selection
  // ******************************************************************
  // Pin choice per output: 1 selects the second pin. The pairing is fixed,
  // so it is a constant and not a register field.
  wire [11:0] use_b    = 12'h290;
  // Internal PWM may gate high-side seven to ten only; output eleven, the
  // half-bridges and the EC pull-down never see it.
  wire [11:0] ipwm_ok  = 12'h3C0;

  assign internal_pwm_run = ipwm_en;
  // The waveform is qualified by the enable so a stale level cannot leak through.
  wire ipwm_sig = ipwm_en & internal_pwm_in;

  // ******************************************************************
  // Per-output protection and gating
  // ******************************************************************
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_out
      opfr_out_state_t st_q;
      logic [31:0]     cnt_q;
      logic [31:0]     dly;
      logic            flag_q;
      // Bulb-mode lamps use their own delay regardless of the rate bit.
      if (g == 6 || g == 7) begin : g_lamp
        assign dly = bulb_mode[g-6] ? BULB_CYC : (rate_sel ? FAST_CYC : SLOW_CYC);
      end else begin : g_std
        assign dly = rate_sel ? FAST_CYC : SLOW_CYC;
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_q   <= OPFR_RUN;
          cnt_q  <= 32'h0;
          flag_q <= 1'b0;
        end else begin
          unique case (st_q)
            OPFR_RUN: begin
              if (overcurrent[g] && out_en[g]) begin
                st_q   <= OPFR_OFF;
                flag_q <= 1'b1;
                cnt_q  <= 32'h0;
              end
            end
            OPFR_OFF: begin
              // Clearing the restart bit mid-delay freezes the count and keeps the driver off.
              if (arst_en[g]) begin
                if (cnt_q + 32'h1 >= dly) begin
                  st_q <= OPFR_RUN;
                end else begin
                  cnt_q <= cnt_q + 32'h1;
                end
              end
            end
          endcase
        end
      end
      wire pin       = use_b[g] ? pwm_in_b : pwm_in_a;
      wire pin_ok    = gate_sel[g] ? pin : 1'b1;
      // Lamps seven to ten follow the internal waveform whenever the unit runs.
      wire ipwm_ok_g = (ipwm_ok[g] && ipwm_en) ? ipwm_sig : 1'b1;
      wire gate_ok   = pin_ok & ipwm_ok_g;
      // Gating is an AND mask, so a gate bit can never switch on a disabled driver.
      assign power_output[g] = out_en[g] & gate_ok & (st_q == OPFR_RUN) & ~supply_shutdown;
      // The flags are sticky; there is no clear port, only reset empties them.
      assign per_output_overcurrent_flag[g] = flag_q;
    end
  endgenerate

  // ******************************************************************
  // Supply fault policy
  // ******************************************************************
  logic sov_q;
  logic suv_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sov_q <= 1'b0;
      suv_q <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle.
      if (supply_over_evt)
        sov_q <= 1'b1;
      else if (supply_flag_clr || (!sup_off && supply_good))
        sov_q <= 1'b0;
      if (supply_under_evt)
        suv_q <= 1'b1;
      else if (supply_flag_clr || (!sup_off && supply_good))
        suv_q <= 1'b0;
    end
  end
  assign supply_over_flag  = sov_q;
  assign supply_under_flag = suv_q;
  // The raw events are included so the drivers drop in the cycle of the event,
  // one cycle before the flags are registered.
  assign supply_shutdown   = sov_q | suv_q | supply_over_evt | supply_under_evt;
  assign global_fault_flag = (|per_output_overcurrent_flag) | sov_q | suv_q;

  // ******************************************************************
  // Reference code and current sense
  // ******************************************************************
  wire clamp = !full_scl && (dac_code > `OPFR_DAC_CLAMP);
  assign dac_out_code = clamp ? `OPFR_DAC_CLAMP : dac_code;

  wire s_ok = (sense == 4'h0) || (sense >= 4'h3 && sense <= 4'h6) || (sense >= 4'h8 && sense <= 4'hA);
  assign sense_active  = s_ok;
  assign sense_out_idx = s_ok ? sense : 4'hF;
endmodule

// File: opfr_ctrl_chk.sv
`timescale 1ns/1ps
// ****
// Port checks against a shadow of the control words.
// ****
module opfr_ctrl_chk (
  input wire logic        clk, rst, reg_wr, pwm_in_a, pwm_in_b, global_fault_flag, internal_pwm_run,
  input wire logic        sense_active, supply_over_evt, supply_over_flag, supply_shutdown,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [11:0] out_en, overcurrent, power_output, per_output_overcurrent_flag,
  input wire logic [5:0]  dac_code, dac_out_code
);
  logic [15:0] c2_q, c3_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {c2_q, c3_q} <= '0;
    else if (reg_wr && reg_addr == 8'h02) c2_q <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h03) c3_q <= reg_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oc_flag_a: assert property ($rose(overcurrent[0]) && out_en[0] |=>
    per_output_overcurrent_flag[0] && global_fault_flag) else $error("oc flag");
  en_mask_a: assert property ((power_output[10:0] & ~out_en[10:0]) == 11'h000) else $error("mask");
  hb_gate_a: assert property (c2_q[7] && !pwm_in_a |-> !power_output[0]) else $error("hb gate");
  out5_gate_a: assert property (c2_q[3] && !pwm_in_b |-> !power_output[4]) else $error("out5");
  hs_gate_a: assert property (c3_q[9] && !pwm_in_b |-> !power_output[7]) else $error("hs gate");
  ipwm_run_a: assert property (internal_pwm_run == c2_q[8]) else $error("ipwm");
  dac_clamp_a: assert property (dac_out_code ==
    ((c2_q[0] || dac_code < 6'h33) ? dac_code : 6'h33)) else $error("dac");
  sense_map_a: assert property (sense_active ==
    (c3_q[3:0] inside {4'h0, [4'h3:4'h6], [4'h8:4'hA]})) else $error("sense");
  supply_set_a: assert property (supply_over_evt |-> supply_shutdown ##1 supply_over_flag) else $error("sup");
  cover property (c2_q[15] && $fell(power_output[0]));
  cover property (c3_q[5] && $rose(power_output[0]));
  cover property (c3_q[4] && supply_over_flag);
endmodule
bind opfr_ctrl opfr_ctrl_chk u_chk (
  .clk, .rst, .reg_wr, .pwm_in_a, .pwm_in_b, .global_fault_flag, .internal_pwm_run, .sense_active,
  .supply_over_evt, .supply_over_flag, .supply_shutdown, .reg_addr, .reg_wdata, .out_en, .overcurrent,
  .power_output, .per_output_overcurrent_flag, .dac_code, .dac_out_code);

// File: opfr_host.sv
`timescale 1ns/1ps
// ****
// Host side of the register port.
// ****
module opfr_host (
  input  wire logic [15:0] reg_rdata,
  input  wire logic        clk,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             supply_flag_clr
);
  initial {reg_wr, reg_addr, reg_wdata, supply_flag_clr} = '0;
  // Data is inverted once released so a stale word is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) reg_addr <= a;
    @(posedge clk) d = reg_rdata;
  endtask
  task automatic clr;
    @(posedge clk) supply_flag_clr <= 1'b1;
    @(posedge clk) supply_flag_clr <= 1'b0;
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// ****
// Register sequences with expected port values.
// ****
module tb;
  logic        clk, rst, reg_wr, internal_pwm_in, pwm_in_a, pwm_in_b, supply_over_evt, supply_under_evt;
  logic        supply_good, supply_flag_clr, global_fault_flag, supply_over_flag, supply_under_flag;
  logic        supply_shutdown, internal_pwm_run, sense_active;
  logic [1:0]  bulb_mode;
  logic [3:0]  sense_out_idx;
  logic [5:0]  dac_code, dac_out_code;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [11:0] out_en, overcurrent, power_output, per_output_overcurrent_flag;
  int          fail_count = 0, n_tests = 0, cyc = 0, n1, n2;
  opfr_ctrl #(.SLOW_CYC(5), .FAST_CYC(3), .BULB_CYC(4)) dut (
    .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .out_en, .overcurrent, .bulb_mode,
    .internal_pwm_in, .pwm_in_a, .pwm_in_b, .dac_code, .supply_over_evt, .supply_under_evt, .supply_good,
    .supply_flag_clr, .power_output, .per_output_overcurrent_flag, .global_fault_flag, .supply_over_flag,
    .supply_under_flag, .supply_shutdown, .internal_pwm_run, .dac_out_code, .sense_out_idx, .sense_active);
  opfr_host host (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata, .supply_flag_clr);
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Returns the cycles an output stays off after a one-cycle overcurrent, 30 meaning never back.
  task automatic oc_time(input int i, output int n);
    @(posedge clk) overcurrent[i] <= 1'b1;
    @(posedge clk) overcurrent[i] <= 1'b0;
    @(negedge clk) chk({15'h0, power_output[i]}, 16'h0000);
    for (n = 0; n < 30 && power_output[i] !== 1'b1; n++) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    {clk, out_en, overcurrent, bulb_mode, internal_pwm_in, pwm_in_a, pwm_in_b, dac_code} = '0;
    {supply_over_evt, supply_under_evt, supply_good, rst} = 4'h1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host.rd(8'h02, rv);
    chk(rv, 16'h0000);
    host.wr(8'h07, 16'hFFFF);
    host.rd(8'h07, rv);
    chk(rv, 16'h0000);
    host.wr(8'h02, 16'h00FC);
    host.wr(8'h03, 16'h07C0);
    @(posedge clk) {out_en, pwm_in_a, pwm_in_b} <= {12'hFFF, 2'b01};
    @(negedge clk) chk({5'h0, power_output[10:0]}, 16'h0290);
    @(posedge clk) {pwm_in_a, pwm_in_b} <= 2'b10;
    @(negedge clk) chk({5'h0, power_output[10:0]}, 16'h056F);
    @(posedge clk) out_en <= 12'h000;
    @(negedge clk) chk({5'h0, power_output[10:0]}, 16'h0000);
    host.wr(8'h02, 16'h01FC);
    @(posedge clk) {out_en, pwm_in_a, pwm_in_b, dac_code} <= {12'hFFF, 2'b11, 6'h3F};
    @(negedge clk) chk({5'h0, power_output[10:0]}, 16'h043F);
    chk({15'h0, internal_pwm_run}, 16'h0001);
    chk({10'h0, dac_out_code}, 16'h0033);
    host.wr(8'h02, 16'h0001);
    @(negedge clk) chk({10'h0, dac_out_code}, 16'h003F);
    for (int c = 0; c < 16; c++) begin
      host.wr(8'h03, 16'(c));
      @(negedge clk) chk({11'h0, sense_active, sense_out_idx}, (c inside {0, [3:6], [8:10]}) ? 16'(16 + c) : 16'h000F);
    end
    host.wr(8'h02, 16'h8000);
    host.wr(8'h03, 16'h0020);
    oc_time(0, n1);
    host.wr(8'h03, 16'h0000);
    oc_time(0, n2);
    chk(16'(n1), 16'h0003);
    chk(16'(n2), 16'h0005);
    oc_time(1, n1);
    chk(16'(n1), 16'h001E);
    chk({13'h0, global_fault_flag, per_output_overcurrent_flag[1:0]}, 16'h0007);
    @(posedge clk) bulb_mode <= 2'b01;
    host.wr(8'h03, 16'h8000);
    oc_time(6, n1);
    host.wr(8'h03, 16'h8020);
    oc_time(6, n2);
    chk(16'(n1), 16'h0004);
    chk(16'(n2), 16'h0004);
    @(posedge clk) {supply_over_evt, supply_good} <= 2'b11;
    @(posedge clk) supply_over_evt <= 1'b0;
    @(negedge clk) chk({15'h0, supply_over_flag}, 16'h0001);
    repeat (2) @(negedge clk);
    chk({15'h0, supply_over_flag}, 16'h0000);
    host.wr(8'h03, 16'h0010);
    @(posedge clk) supply_over_evt <= 1'b1;
    @(posedge clk) supply_over_evt <= 1'b0;
    repeat (4) @(negedge clk);
    chk({15'h0, supply_over_flag}, 16'h0001);
    host.clr;
    @(negedge clk) chk({15'h0, supply_over_flag}, 16'h0000);
    host.rd(8'h03, rv);
    chk(rv, 16'h0010);
    @(posedge clk) supply_under_evt <= 1'b1;
    @(negedge clk) chk({14'h0, supply_shutdown, |power_output}, 16'h0002);
    @(posedge clk) supply_under_evt <= 1'b0;
    repeat (2) @(negedge clk);
    chk({14'h0, supply_under_flag, supply_shutdown}, 16'h0003);
    host.clr;
    @(negedge clk) chk({14'h0, supply_under_flag, supply_shutdown}, 16'h0000);
    host.wr(8'h02, 16'h0102);
    @(posedge clk) {internal_pwm_in, pwm_in_a} <= 2'b10;
    @(negedge clk) chk({4'h0, power_output}, 16'h07FD);
    @(posedge clk) pwm_in_a <= 1'b1;
    @(negedge clk) chk({4'h0, power_output}, 16'h0FFD);
    @(posedge clk) internal_pwm_in <= 1'b0;
    @(negedge clk) chk({4'h0, power_output}, 16'h0C3D);
    test_done;
  end
endmodule
